// >>> include/lts_consts.svh
// Register offsets, field positions and reset values of the logic tile glue
`ifndef LTS_CONSTS_SVH
`define LTS_CONSTS_SVH
`define LTS_A_CTRL 8'h00
`define LTS_A_STATUS 8'h04
`define LTS_A_STSEL 8'h08
`define LTS_A_STMODE 8'h0c
`define LTS_A_DPCFG 8'h10
`define LTS_A_DPOSEL 8'h14
`define LTS_A_DPDATA 8'h18
`define LTS_A_FIFO0 8'h1c
`define LTS_A_FIFO1 8'h20
`define LTS_A_FIFOSTAT 8'h24
`define LTS_A_CLKCFG 8'h28
`define LTS_A_IRQSEL 8'h2c
`define LTS_A_DMASEL 8'h30
`define LTS_A_IOCFG 8'h34
`define LTS_A_SEG0 8'h38
`define LTS_A_SEG1 8'h3c
`define LTS_A_SEG2 8'h40
// DPCFG fields
`define LTS_DP_CSRC 0
`define LTS_DP_SHIFT 2
`define LTS_DP_F0DIR 4
`define LTS_DP_F1DIR 5
// CLKCFG fields: four 2-bit modes, then ctrl bit index, then route index
`define LTS_CK_CESEL 8
`define LTS_CK_RTSEL 11
// IOCFG fields
`define LTS_IO_INSYNC 8
`define LTS_IO_OEMODE 16
// Reset value of every register
`define LTS_RST_VALUE 32'h0000_0000
`endif

// >>> include/lts_pkg.sv
// Types shared by the logic tile glue modules
package lts_pkg;
  typedef enum logic [2:0] {
    OP_HOLD, OP_INC, OP_DEC, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR
  } lts_op_type;
  typedef enum logic [1:0] {CS_ROUTE, CS_CHAIN, CS_HELD, CS_ZERO} lts_csrc_type;
  typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} lts_shift_type;
  typedef enum logic [1:0] {CK_OFF, CK_ON, CK_CTRL, CK_ROUTE} lts_ckmode_type;
  typedef enum logic [1:0] {OE_ALL8, OE_QUADS, OE_PAIRS, OE_SINGLE} lts_oemode_type;
  typedef enum logic {FD_IN, FD_OUT} lts_fdir_type;
endpackage

// >>> rtl/lts_fifo.sv
// Small byte FIFO used as a datapath input or output buffer
`timescale 1ns/1ps
`default_nettype none
module lts_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pushValid,
  output logic pushReady,
  input wire logic [W-1:0] pushData,
  output logic popValid,
  input wire logic popReady,
  output logic [W-1:0] popData,
  output logic [$clog2(DEPTH):0] count
);
  import lts_pkg::*;
  localparam int AW = $clog2(DEPTH);

  // Pointers wrap naturally only for a power of two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("lts_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } lts_fifo_state_type;

  lts_fifo_state_type s_ff;
  lts_fifo_state_type nxt_s;
  logic doPush;
  logic doPop;

  // Honest full and empty straight from the count
  assign pushReady = (s_ff.cnt != (AW+1)'(DEPTH));
  assign popValid = (s_ff.cnt != '0);
  assign popData = s_ff.mem[s_ff.rp];
  assign count = s_ff.cnt;
  assign doPush = pushValid & pushReady;
  assign doPop = popValid & popReady;

  // Next state of storage and pointers
  always_comb begin
    nxt_s = s_ff;
    if (doPush) begin
      nxt_s.mem[s_ff.wp] = pushData;
      nxt_s.wp = s_ff.wp + 1'b1;
    end
    if (doPop) begin
      nxt_s.rp = s_ff.rp + 1'b1;
    end
    nxt_s.cnt = s_ff.cnt + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop};
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/lts_tile.sv
// Logic tile glue: datapath routing, status and control, clock enables, request and pin routing
// What this block does
// - Carry, shift data and condition chain to and from neighbouring datapaths.
// - ALU carry and shift-out are registered and selectable as later inputs.
// - Datapath meets the routing through exactly six inputs and six outputs.
// - Routed inputs pick each cycle's operation and supply serial data.
// - Each routed output selects a condition or the serial data output.
// - Bus-writable control register, every bit driven into the routing.
// - Read-only status register presents routed signals directly as read data.
// - Status bits can hold a pulse until read; the read clears them.
// - Every status bit has its own configurable routing connection; each control bit drives its own fixed ctrlOut line.
// - Each subblock has its own clock enable selection.
// - A chosen control bit serves as clock enable for chosen tiles.
// - Routing channel carries 96 wires, segmentable wire by wire.
// - Any routed signal or peripheral request selectable as interrupt or DMA.
// - Several independent interrupt requests, each separately routed.
// - Eight-bit port: sixteen data routes and four drive-strength routes.
// - Optional output register stage and optional two-flop input synchroniser.
// - Four routed output enables, grouped from all eight to four single pins.
// - Each pin has input and output connections for bidirectional use.
// - Two four-byte FIFOs, each configurable as bus input or bus output.
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lts_consts.svh"
module lts_tile #(
  parameter int ROUTE_W = 16,
  parameter int PERIPH_W = 8,
  parameter int NIRQ = 4,
  parameter int NDMA = 2,
  parameter int CHAN_W = 96,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [ROUTE_W-1:0] routeIn,
  input wire logic [PERIPH_W-1:0] periphReq,
  input wire logic [5:0] dpIn,
  output logic [5:0] dpOut,
  input wire logic chainCarryIn,
  input wire logic chainShiftIn,
  input wire logic chainCondIn,
  output logic chainCarryOut,
  output logic chainShiftOut,
  output logic chainCondOut,
  output logic [7:0] ctrlOut,
  output logic ctrlClkEn,
  output logic [1:0] pldClkEn,
  output logic [NIRQ-1:0] irqReq,
  output logic [NDMA-1:0] dmaReq,
  input wire logic [CHAN_W-1:0] chanIn,
  output logic [CHAN_W-1:0] chanOut,
  input wire logic [7:0] ioOutRoute,
  output logic [7:0] ioInRoute,
  input wire logic [3:0] driveRoute,
  output logic [3:0] pinDrive,
  input wire logic [3:0] oeRoute,
  input wire logic [7:0] pinIn,
  output logic [7:0] pinOut,
  output logic [7:0] pinOeN
);
  import lts_pkg::*;
  localparam int SRC_W = ROUTE_W + PERIPH_W;
  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  localparam int TD_W = 14;

  // Selectors are 4 and 5 bits wide and the segment store holds 96 wires
  if (ROUTE_W > 16 || SRC_W > 32 || NIRQ > 4 || NDMA > 2 || CHAN_W > 96
      || NIRQ < 1 || NDMA < 1) begin : g_chk
    $error("lts_tile: parameter out of the supported range");
  end

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [7:0] ctrl;
    logic [7:0] held;
    logic [7:0] stMode;
    logic [31:0] stSel;
    lts_csrc_type carrySrc;
    lts_shift_type shMode;
    lts_fdir_type f0Dir;
    lts_fdir_type f1Dir;
    logic [17:0] doSel;
    logic [7:0] acc;
    logic [7:0] dreg;
    logic carry;
    logic shOut;
    logic chZero;
    logic [5:0] dpOut;
    lts_ckmode_type [3:0] ckMode;
    logic [2:0] ceSel;
    logic [3:0] rtSel;
    logic ceOut;
    logic [1:0] pldEn;
    logic [31:0] irqSel;
    logic [15:0] dmaSel;
    logic [NIRQ-1:0] irq;
    logic [NDMA-1:0] dma;
    logic [7:0] outSync;
    logic [7:0] inSync;
    lts_oemode_type oeMode;
    logic [95:0] seg;
    logic [7:0] pinSync1;
    logic [7:0] pinSync2;
    logic [7:0] pinOutQ;
  } lts_state_type;

  lts_state_type s_ff;
  lts_state_type nxt_s;

  // Pick one bit out of a padded source vector
  function automatic logic pick(input logic [31:0] v, input logic [4:0] i);
    return v[i];
  endfunction

  // Byte-lane merge of a write into the current register value
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Enable of one subblock from its mode
  function automatic logic ckEn(input lts_ckmode_type m, input logic cbit, input logic rbit);
    case (m)
      CK_ON: return 1'b1;
      CK_CTRL: return cbit;
      CK_ROUTE: return rbit;
      default: return 1'b0;
    endcase
  endfunction

  // Output enable of pin p under the grouping mode
  function automatic logic oeOf(input lts_oemode_type m, input logic [3:0] oe, input int p);
    case (m)
      OE_ALL8: return oe[0];
      OE_QUADS: return oe[p/4];
      OE_PAIRS: return oe[p/2];
      OE_SINGLE: return (p < 4) ? oe[p] : 1'b0;
      default: return 1'b0;
    endcase
  endfunction

  logic req;
  logic commit;
  logic [7:0] wa;
  logic [31:0] rd;
  logic [31:0] w;
  logic [7:0] stLive;
  logic [7:0] stVal;
  logic [31:0] srcVec;
  logic [31:0] rtVec;
  logic dpRun;
  logic stRun;
  logic cin;
  logic sin;
  lts_op_type op;
  logic [8:0] sum9;
  logic [7:0] shv;
  logic so;
  logic [7:0] cond;
  logic [1:0] fPushV;
  logic [1:0] fPushR;
  logic [1:0] fPopV;
  logic [1:0] fPopR;
  logic [1:0][7:0] fPushD;
  logic [1:0][7:0] fPopD;
  logic [1:0][CW-1:0] fCnt;
  logic [1:0] fDir;
  logic [1:0] busFifoW;
  logic [1:0] busFifoR;
  logic [TD_W-1:0] tileDrive;

  // Bus decode; a request commits at the edge where the master sees ack
  assign req = wb_cyc_i & wb_stb_i;
  assign commit = req & s_ff.ack;
  assign wa = {wb_adr_i[7:2], 2'b00};
  assign rtVec = 32'(routeIn);
  assign srcVec = 32'({periphReq, routeIn});
  assign fDir = {s_ff.f1Dir, s_ff.f0Dir};
  assign busFifoW[0] = commit & wb_we_i & wb_sel_i[0] & (wa == `LTS_A_FIFO0);
  assign busFifoW[1] = commit & wb_we_i & wb_sel_i[0] & (wa == `LTS_A_FIFO1);
  // Pop where the byte is latched, so a push before ack cannot be lost
  assign busFifoR[0] = req & ~s_ff.ack & ~wb_we_i & (wa == `LTS_A_FIFO0);
  assign busFifoR[1] = req & ~s_ff.ack & ~wb_we_i & (wa == `LTS_A_FIFO1);

  // Per-subblock enables; plain enables since every flop clocks each edge
  assign dpRun = ckEn(s_ff.ckMode[0], s_ff.ctrl[s_ff.ceSel], rtVec[s_ff.rtSel]);
  assign stRun = ckEn(s_ff.ckMode[1], s_ff.ctrl[s_ff.ceSel], rtVec[s_ff.rtSel]);

  // Each status bit has its own routing selector
  always_comb begin
    stLive = '0;
    for (int i = 0; i < 8; i++) begin
      stLive[i] = pick(rtVec, {1'b0, s_ff.stSel[4*i +: 4]});
    end
  end
  assign stVal = (s_ff.held & s_ff.stMode) | (stLive & ~s_ff.stMode);

  // FIFO feeds: bus side or datapath side by direction
  generate
    for (genvar f = 0; f < 2; f++) begin : g_fifo
      assign fPushV[f] = (fDir[f] == FD_IN) ? busFifoW[f] : (dpRun & dpIn[5]);
      assign fPushD[f] = (fDir[f] == FD_IN) ? wb_dat_i[7:0] : s_ff.acc;
      assign fPopR[f] = (fDir[f] == FD_IN) ? (dpRun & dpIn[5]) : busFifoR[f];
      lts_fifo #(
        .W(8),
        .DEPTH(FIFO_DEPTH)
      ) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .pushValid(fPushV[f]),
        .pushReady(fPushR[f]),
        .pushData(fPushD[f]),
        .popValid(fPopV[f]),
        .popReady(fPopR[f]),
        .popData(fPopD[f]),
        .count(fCnt[f])
      );
    end
  endgenerate

  // Register read mux
  always_comb begin
    rd = `LTS_RST_VALUE;
    case (wa)
      `LTS_A_CTRL: rd = 32'(s_ff.ctrl);
      `LTS_A_STATUS: rd = 32'(stVal);
      `LTS_A_STSEL: rd = s_ff.stSel;
      `LTS_A_STMODE: rd = 32'(s_ff.stMode);
      `LTS_A_DPCFG: rd = 32'({s_ff.f1Dir, s_ff.f0Dir, s_ff.shMode, s_ff.carrySrc});
      `LTS_A_DPOSEL: rd = 32'(s_ff.doSel);
      `LTS_A_DPDATA: rd = 32'({s_ff.dreg, s_ff.acc});
      `LTS_A_FIFO0: rd = 32'(fPopV[0] ? fPopD[0] : 8'h00);
      `LTS_A_FIFO1: rd = 32'(fPopV[1] ? fPopD[1] : 8'h00);
      `LTS_A_FIFOSTAT: rd = 32'({fCnt[1], fCnt[0]});
      `LTS_A_CLKCFG: rd = 32'({s_ff.rtSel, s_ff.ceSel, s_ff.ckMode});
      `LTS_A_IRQSEL: rd = s_ff.irqSel;
      `LTS_A_DMASEL: rd = 32'(s_ff.dmaSel);
      `LTS_A_IOCFG: rd = 32'({s_ff.oeMode, s_ff.inSync, s_ff.outSync});
      `LTS_A_SEG0: rd = s_ff.seg[31:0];
      `LTS_A_SEG1: rd = s_ff.seg[63:32];
      `LTS_A_SEG2: rd = s_ff.seg[95:64];
      default: rd = `LTS_RST_VALUE;
    endcase
  end
  assign w = wmerge(rd, wb_dat_i, wb_sel_i);

  // ALU operand sources: routed, chained or held from the previous cycle
  always_comb begin
    case (s_ff.carrySrc)
      CS_ROUTE: begin
        cin = dpIn[3];
        sin = dpIn[4];
      end
      CS_CHAIN: begin
        cin = chainCarryIn;
        sin = chainShiftIn;
      end
      CS_HELD: begin
        cin = s_ff.carry;
        sin = s_ff.shOut;
      end
      default: begin
        cin = 1'b0;
        sin = 1'b0;
      end
    endcase
  end

  // ALU then shifter; the operation comes from the routing each cycle
  assign op = lts_op_type'(dpIn[2:0]);
  always_comb begin
    case (op)
      OP_INC: sum9 = {1'b0, s_ff.acc} + 9'h001;
      OP_DEC: sum9 = {1'b0, s_ff.acc} - 9'h001;
      OP_ADD: sum9 = {1'b0, s_ff.acc} + {1'b0, s_ff.dreg} + {8'h00, cin};
      OP_SUB: sum9 = {1'b0, s_ff.acc} - {1'b0, s_ff.dreg} - {8'h00, cin};
      OP_AND: sum9 = {1'b0, s_ff.acc & s_ff.dreg};
      OP_OR: sum9 = {1'b0, s_ff.acc | s_ff.dreg};
      OP_XOR: sum9 = {1'b0, s_ff.acc ^ s_ff.dreg};
      default: sum9 = {s_ff.carry, s_ff.acc};
    endcase
    case (s_ff.shMode)
      SH_LEFT: begin
        shv = {sum9[6:0], sin};
        so = sum9[7];
      end
      SH_RIGHT: begin
        shv = {sin, sum9[7:1]};
        so = sum9[0];
      end
      SH_SWAP: begin
        shv = {sum9[3:0], sum9[7:4]};
        so = 1'b0;
      end
      default: begin
        shv = sum9[7:0];
        so = 1'b0;
      end
    endcase
  end

  // Conditions offered to the routed outputs; zero is chained for wide compares
  assign cond = {~fPushR[1], ~fPopV[0], so, sum9[8],
                 s_ff.acc < s_ff.dreg, s_ff.acc == s_ff.dreg, &s_ff.acc,
                 (s_ff.acc == 8'h00) & chainCondIn};

  // Next state
  always_comb begin
    nxt_s = s_ff;
    // Bus answer one cycle after the request, dropped the cycle after
    nxt_s.ack = req & ~s_ff.ack;
    if (req & ~s_ff.ack) begin
      nxt_s.rdat = rd;
    end
    // Read clears only the held bits it actually reported
    if (commit & ~wb_we_i & (wa == `LTS_A_STATUS)) begin
      nxt_s.held = s_ff.held & ~(s_ff.rdat[7:0] & s_ff.stMode);
    end
    // Capture after the clear, so a new pulse wins
    nxt_s.held = nxt_s.held | (stLive & s_ff.stMode & {8{stRun}});
    // Datapath step
    if (dpRun) begin
      nxt_s.acc = shv;
      nxt_s.carry = sum9[8];
      nxt_s.shOut = so;
      if (dpIn[5] & (s_ff.f0Dir == FD_IN) & fPopV[0]) begin
        nxt_s.dreg = fPopD[0];
      end
      if (dpIn[5] & (s_ff.f1Dir == FD_IN) & fPopV[1]) begin
        nxt_s.acc = fPopD[1];
      end
    end
    nxt_s.chZero = cond[0];
    for (int i = 0; i < 6; i++) begin
      nxt_s.dpOut[i] = cond[s_ff.doSel[3*i +: 3]];
    end
    // Clock enables handed to the logic blocks and to other tiles
    nxt_s.pldEn[0] = ckEn(s_ff.ckMode[2], s_ff.ctrl[s_ff.ceSel], rtVec[s_ff.rtSel]);
    nxt_s.pldEn[1] = ckEn(s_ff.ckMode[3], s_ff.ctrl[s_ff.ceSel], rtVec[s_ff.rtSel]);
    nxt_s.ceOut = s_ff.ctrl[s_ff.ceSel];
    // Request selectors, one per line
    for (int i = 0; i < NIRQ; i++) begin
      nxt_s.irq[i] = pick(srcVec, s_ff.irqSel[8*i +: 5]);
    end
    for (int i = 0; i < NDMA; i++) begin
      nxt_s.dma[i] = pick(srcVec, s_ff.dmaSel[8*i +: 5]);
    end
    // Pin stages; the first sync flop feeds only the second
    nxt_s.pinSync1 = pinIn;
    nxt_s.pinSync2 = s_ff.pinSync1;
    nxt_s.pinOutQ = ioOutRoute;
    // Register writes, taken after the datapath so software wins
    if (commit & wb_we_i) begin
      case (wa)
        `LTS_A_CTRL: nxt_s.ctrl = w[7:0];
        `LTS_A_STSEL: nxt_s.stSel = w;
        `LTS_A_STMODE: nxt_s.stMode = w[7:0];
        `LTS_A_DPCFG: begin
          nxt_s.carrySrc = lts_csrc_type'(w[`LTS_DP_CSRC +: 2]);
          nxt_s.shMode = lts_shift_type'(w[`LTS_DP_SHIFT +: 2]);
          nxt_s.f0Dir = lts_fdir_type'(w[`LTS_DP_F0DIR]);
          nxt_s.f1Dir = lts_fdir_type'(w[`LTS_DP_F1DIR]);
        end
        `LTS_A_DPOSEL: nxt_s.doSel = w[17:0];
        `LTS_A_DPDATA: begin
          nxt_s.acc = w[7:0];
          nxt_s.dreg = w[15:8];
        end
        `LTS_A_CLKCFG: begin
          for (int k = 0; k < 4; k++) begin
            nxt_s.ckMode[k] = lts_ckmode_type'(w[2*k +: 2]);
          end
          nxt_s.ceSel = w[`LTS_CK_CESEL +: 3];
          nxt_s.rtSel = w[`LTS_CK_RTSEL +: 4];
        end
        `LTS_A_IRQSEL: nxt_s.irqSel = w;
        `LTS_A_DMASEL: nxt_s.dmaSel = w[15:0];
        `LTS_A_IOCFG: begin
          nxt_s.outSync = w[7:0];
          nxt_s.inSync = w[`LTS_IO_INSYNC +: 8];
          nxt_s.oeMode = lts_oemode_type'(w[`LTS_IO_OEMODE +: 2]);
        end
        `LTS_A_SEG0: nxt_s.seg[31:0] = w;
        `LTS_A_SEG1: nxt_s.seg[63:32] = w;
        `LTS_A_SEG2: nxt_s.seg[95:64] = w;
        default: nxt_s.ack = nxt_s.ack;
      endcase
    end
  end

  // State register; everything clears, control and held bits included
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Bus and routing outputs
  assign wb_dat_o = s_ff.rdat;
  assign wb_ack_o = s_ff.ack;
  assign dpOut = s_ff.dpOut;
  assign chainCarryOut = s_ff.carry;
  assign chainShiftOut = s_ff.shOut;
  assign chainCondOut = s_ff.chZero;
  assign ctrlOut = s_ff.ctrl;
  assign ctrlClkEn = s_ff.ceOut;
  assign pldClkEn = s_ff.pldEn;
  assign irqReq = s_ff.irq;
  assign dmaReq = s_ff.dma;

  // Broken wires carry tile outputs instead of the upstream segment
  assign tileDrive = {s_ff.dpOut, s_ff.ctrl};
  generate
    for (genvar i = 0; i < CHAN_W; i++) begin : g_seg
      assign chanOut[i] = s_ff.seg[i] ? tileDrive[i % TD_W] : chanIn[i];
    end
  endgenerate

  // Port pins; the raw input path exists only for combinational feed-through
  assign pinDrive = driveRoute;
  generate
    for (genvar p = 0; p < 8; p++) begin : g_pin
      assign ioInRoute[p] = s_ff.inSync[p] ? s_ff.pinSync2[p] : pinIn[p];
      assign pinOut[p] = s_ff.outSync[p] ? s_ff.pinOutQ[p] : ioOutRoute[p];
      assign pinOeN[p] = ~oeOf(s_ff.oeMode, oeRoute, p);
    end
  endgenerate
endmodule
`default_nettype wire

// >>> test/lts_wb_master.sv
// System bus master model issuing classic single Wishbone cycles
`timescale 1ns/1ps
`default_nettype none
module lts_wb_master (
  input wire logic clk_sys,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat,
  input wire logic ack,
  input wire logic [31:0] q
);
  initial {cyc, stb, we, adr, sel, dat} = '0;
  // One cycle; request held until ack is sampled, then one idle cycle
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    {cyc, stb, we, adr, sel, dat} <= {1'b1, 1'b1, w, a, 4'hf, d};
    do @(posedge clk_sys); while (ack !== 1'b1);
    r = q;
    {cyc, stb, we} <= 3'b000;
  endtask
endmodule
`default_nettype wire

// >>> test/lts_tile_checker.sv
// Port relation checks for the logic tile glue
`timescale 1ns/1ps
`default_nettype none
`include "lts_consts.svh"
module lts_tile_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] ctrlOut,
  input wire logic [7:0] ioOutRoute,
  input wire logic [7:0] ioInRoute,
  input wire logic [3:0] driveRoute,
  input wire logic [3:0] pinDrive,
  input wire logic [7:0] pinIn,
  input wire logic [7:0] pinOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Request taken at this edge
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  sequence s_ctrl_wr;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == `LTS_A_CTRL && wb_sel_i[0];
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack; req |=> s_ack_pulse; endproperty
  property p_ctrl; s_ctrl_wr |=> ctrlOut == $past(wb_dat_i[7:0]); endproperty
  property p_hold; !(wb_cyc_i && wb_we_i) |=> $stable(ctrlOut); endproperty
  property p_rst; $fell(rst) |-> ctrlOut == 8'h00 && !wb_ack_o; endproperty
  property p_dat; !req |=> $stable(wb_dat_o); endproperty
  property p_sts; req && !wb_we_i && wb_adr_i == `LTS_A_STATUS |=> wb_dat_o[31:8] == 24'h0;
  endproperty
  property p_drv; pinDrive == driveRoute; endproperty
  // Either the direct pin or its two-flop synchronised copy
  // Judged per pin, since each pin chooses its own path
  property p_in; ((ioInRoute ^ pinIn) & (ioInRoute ^ $past(pinIn, 2))) == 8'h00; endproperty
  property p_out; ((pinOut ^ ioOutRoute) & (pinOut ^ $past(ioOutRoute))) == 8'h00;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
  a_ctrl: assert property (p_ctrl) else $error("control write not applied");
  a_hold: assert property (p_hold) else $error("control changed without write");
  a_rst: assert property (p_rst) else $error("state not clear after reset");
  a_dat: assert property (p_dat) else $error("read data moved between requests");
  a_sts: assert property (p_sts) else $error("status read beyond eight bits");
  a_drv: assert property (p_drv) else $error("drive strength not passed on");
  a_in: assert property (p_in) else $error("pin input path wrong");
  a_out: assert property (p_out) else $error("pin output path wrong");
endmodule
bind lts_tile lts_tile_checker u_chk (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ctrlOut, .ioOutRoute,
  .ioInRoute, .driveRoute, .pinDrive, .pinIn, .pinOut);
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the logic tile glue
`timescale 1ns/1ps
`default_nettype none
`include "lts_consts.svh"
module tb;
  logic clk_sys = 0, rst = 1, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, ctrlOut, ioInRoute, pinOut, pinOeN;
  logic [3:0] wb_sel_i, pinDrive;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  logic [15:0] routeIn = 0;
  logic [7:0] periphReq = 0, ioOutRoute = 0, pinIn = 0;
  logic [5:0] dpIn = 0, dpOut;
  logic chainCarryIn = 0, chainShiftIn = 0, chainCondIn = 1;
  logic chainCarryOut, chainShiftOut, chainCondOut, ctrlClkEn;
  logic [1:0] pldClkEn, dmaReq;
  logic [3:0] irqReq, driveRoute = 0, oeRoute = 0;
  logic [95:0] chanIn = '1, chanOut;
  int n_errors = 0, tests_run = 0, ticks = 0;
  lts_tile dut (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .routeIn, .periphReq, .dpIn, .dpOut, .chainCarryIn,
    .chainShiftIn, .chainCondIn, .chainCarryOut, .chainShiftOut, .chainCondOut, .ctrlOut,
    .ctrlClkEn, .pldClkEn, .irqReq, .dmaReq, .chanIn, .chanOut, .ioOutRoute, .ioInRoute,
    .driveRoute, .pinDrive, .oeRoute, .pinIn, .pinOut, .pinOeN);
  lts_wb_master m (.clk_sys, .cyc(wb_cyc_i), .stb(wb_stb_i), .we(wb_we_i), .adr(wb_adr_i),
    .sel(wb_sel_i), .dat(wb_dat_i), .ack(wb_ack_o), .q(wb_dat_o));
  initial forever #12.5 clk_sys = ~clk_sys;
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task clk(input int n); repeat (n) @(posedge clk_sys); endtask
  task wr(input logic [7:0] a, input logic [31:0] d); m.xfer(1'b1, a, d, r); endtask
  task rd(input logic [7:0] a); m.xfer(1'b0, a, 32'h0, r); endtask
  // Expected enables per grouping mode; pins 4-7 stay off when paired singly
  function automatic logic [7:0] oe_exp(input int md, input logic [3:0] o);
    case (md)
      0: return {8{~o[0]}};
      1: return {{4{~o[1]}}, {4{~o[0]}}};
      2: return {{2{~o[3]}}, {2{~o[2]}}, {2{~o[1]}}, {2{~o[0]}}};
      default: return {4'hf, ~o};
    endcase
  endfunction
  task t_reset;
    logic [7:0] a[6];
    a = '{`LTS_A_CTRL, `LTS_A_STATUS, `LTS_A_DPCFG, `LTS_A_CLKCFG, `LTS_A_IOCFG, 8'hfc};
    foreach (a[i]) begin
      rd(a[i]);
      chk(r, 32'h0);
    end
    $display("t_reset done");
  endtask
  task t_ctrl;
    wr(`LTS_A_SEG0, 32'h3);
    wr(`LTS_A_CTRL, 32'h5a);
    #1;
    chk(ctrlOut, 8'h5a);
    chk(chanOut[2:0], 3'b110);
    rd(`LTS_A_CTRL);
    chk(r, 32'h5a);
    wr(`LTS_A_STATUS, 32'hff);
    rd(`LTS_A_STATUS);
    chk(r, 32'h0);
    $display("t_ctrl done");
  endtask
  task t_status;
    wr(`LTS_A_CLKCFG, 32'h4);
    wr(`LTS_A_STSEL, 32'h53);
    wr(`LTS_A_STMODE, 32'h1);
    @(posedge clk_sys) routeIn <= 16'h0028;
    @(posedge clk_sys) routeIn <= 16'h0020;
    clk(2);
    rd(`LTS_A_STATUS);
    chk(r, 32'h3);
    rd(`LTS_A_STATUS);
    chk(r, 32'h2);
    routeIn <= 0;
    $display("t_status done");
  endtask
  task t_clk;
    wr(`LTS_A_CTRL, 32'h4);
    wr(`LTS_A_CLKCFG, 32'h3ad4);
    routeIn <= 16'h0080;
    clk(3);
    chk({ctrlClkEn, pldClkEn}, 3'b111);
    routeIn <= 0;
    wr(`LTS_A_CTRL, 32'h0);
    clk(3);
    chk({ctrlClkEn, pldClkEn}, 3'b001);
    $display("t_clk done");
  endtask
  task t_irq;
    wr(`LTS_A_IRQSEL, 32'h0912);
    wr(`LTS_A_DMASEL, 32'h0009);
    periphReq <= 8'h04;
    clk(3);
    chk({dmaReq, irqReq}, 6'b00_0001);
    {periphReq, routeIn} <= {8'h00, 16'h0200};
    clk(3);
    chk({dmaReq, irqReq}, 6'b01_0010);
    routeIn <= 0;
    $display("t_irq done");
  endtask
  task t_io;
    wr(`LTS_A_IOCFG, 32'h0102);
    @(posedge clk_sys) {pinIn, ioOutRoute, driveRoute, oeRoute} <= {8'h05, 8'h03, 8'h0a6};
    #1;
    chk({ioInRoute[2:0], pinOut[1:0]}, 5'b100_01);
    @(posedge clk_sys) #1;
    chk({ioInRoute[2:0], pinOut[1:0]}, 5'b100_11);
    @(posedge clk_sys) #1;
    chk({ioInRoute[2:0], pinOut[1:0]}, 5'b101_11);
    chk(pinDrive, 4'ha);
    for (int md = 0; md < 4; md++) begin
      wr(`LTS_A_IOCFG, 32'(md) << 16);
      clk(2);
      chk(pinOeN, oe_exp(md, oeRoute));
    end
    $display("t_io done");
  endtask
  task t_dp;
    wr(`LTS_A_CLKCFG, 32'h1);
    wr(`LTS_A_DPOSEL, 32'h1);
    wr(`LTS_A_DPDATA, 32'h0);
    @(posedge clk_sys) dpIn <= 6'd1;
    repeat (5) @(posedge clk_sys);
    dpIn <= 6'd0;
    rd(`LTS_A_DPDATA);
    chk(r[7:0], 8'h05);
    wr(`LTS_A_DPDATA, 32'hff);
    clk(2);
    chk(dpOut, 6'h01);
    @(posedge clk_sys) dpIn <= 6'd1;
    @(posedge clk_sys) dpIn <= 6'd0;
    clk(2);
    chk({chainCarryOut, dpOut}, 7'b1_111110);
    $display("t_dp done");
  endtask
  task t_fifo;
    wr(`LTS_A_CLKCFG, 32'h3);
    wr(`LTS_A_DPCFG, 32'h26);
    wr(`LTS_A_DPDATA, 32'ha5);
    wr(`LTS_A_FIFO0, 32'h3c);
    rd(`LTS_A_FIFOSTAT);
    chk(r, 32'h1);
    // One step: FIFO0 into dreg, acc into FIFO1, held shift left
    @(posedge clk_sys) {routeIn, dpIn} <= {16'h0001, 6'h20};
    @(posedge clk_sys) {routeIn, dpIn} <= 22'h0;
    rd(`LTS_A_FIFO1);
    chk(r, 32'ha5);
    rd(`LTS_A_DPDATA);
    chk(r, 32'h3c4a);
    chk(chainShiftOut, 1'b1);
    rd(`LTS_A_FIFOSTAT);
    chk(r, 32'h0);
    rd(`LTS_A_FIFO1);
    chk(r, 32'h0);
    $display("t_fifo done");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk(8);
    rst <= 0;
    t_reset();
    t_ctrl();
    t_status();
    t_clk();
    t_irq();
    t_io();
    t_dp();
    t_fifo();
    report_and_stop();
  end
endmodule
`default_nettype wire
